// file: pkg/bia_pkg.sv
// constants and types of the bidding interrupt arbiter
//Contract
//(R01) eighteen bidding sources: four rx, four tx, four break, four change of state, two timers
//(R02) each bid mixes fixed bits, programmed bits and the source's live condition; here rx and tx bids hold no programmed bits
//(R03) bids are compared with the programmed threshold once per crystal clock cycle
//(R04) an interrupt request rises when some bid exceeds the threshold
//(R05) the winning bid itself, not the threshold, is loaded into the capture register
//(R06) capture loads on interrupt acknowledge and on the refresh capture command
//(R07) captured value tells channel, source type and fifo byte count in one read
//(R08) captured value steers vector modification and the global pointer locations
//(R09) global receive read returns the captured receiver's fifo data
//(R10) global transmit write sends the byte to the captured transmitter's fifo
//(R11) global count and channel reads return those captured fields right justified
//(R12) the four global locations store nothing; they decode the captured value
//(R13) bid bits 1:0 channel, 4:2 type, upper bits count, error or priority
//(R14) type codes 111,011,x10,100,001,101,000; the numerically largest bid wins
//(R15) idle timer, empty receive fifo and full transmit fifo do not bid
//(R16) six bit threshold meets bid bits 7:2; ties go to highest channel
//(R17) vector format: 00 full, 01 six bits+channel, 10 three bits+type+channel, 11 all ones
//(R18) request stays high while any enabled bid exceeds threshold, drops when none does
package bia_pkg;
	localparam int BIA_NSRC = 18;
	localparam int BIA_NCH = 4;
	localparam int BIA_NCT = 2;
	// apb byte addresses
	localparam logic [7:0] BIA_A_CTRL = 8'h00;
	localparam logic [7:0] BIA_A_VBASE = 8'h04;
	localparam logic [7:0] BIA_A_CAPT = 8'h08;
	localparam logic [7:0] BIA_A_CMD = 8'h0C;
	localparam logic [7:0] BIA_A_GCOUNT = 8'h10;
	localparam logic [7:0] BIA_A_GCHAN = 8'h14;
	localparam logic [7:0] BIA_A_GRX = 8'h18;
	localparam logic [7:0] BIA_A_GTX = 8'h1C;
	localparam logic [7:0] BIA_A_SRCEN = 8'h20;
	localparam logic [7:0] BIA_A_BRKPRI = 8'h24;
	localparam logic [7:0] BIA_A_COSPRI = 8'h28;
	localparam logic [7:0] BIA_A_CTPRI = 8'h2C;
	localparam logic [7:0] BIA_A_STAT = 8'h30;
	localparam logic [7:0] BIA_A_MASK = 8'h34;
	// reset values
	localparam logic [7:0] BIA_RST_CTRL = 8'h00;
	localparam logic [7:0] BIA_RST_VBASE = 8'h0F;
	localparam logic [17:0] BIA_RST_SRCEN = 18'h00000;
	// source type codes in bid bits 4:2
	localparam logic [1:0] BIA_RX_LOW = 2'b11;
	localparam logic [1:0] BIA_TX_LOW = 2'b10;
	localparam logic [2:0] BIA_T_BRK = 3'b100;
	localparam logic [2:0] BIA_T_COS = 3'b001;
	localparam logic [2:0] BIA_T_CT = 3'b101;
	localparam logic [7:0] BIA_NO_BID = 8'h00;
	// vector formats
	localparam logic [1:0] BIA_VF_FULL = 2'b00;
	localparam logic [1:0] BIA_VF_CH = 2'b01;
	localparam logic [1:0] BIA_VF_TYPE = 2'b10;
	localparam logic [7:0] BIA_VEC_INHIBIT = 8'hFF;
	// status bit positions
	localparam int BIA_ST_REQ = 0;
	localparam int BIA_ST_CAPT = 1;
	localparam int BIA_ST_MISS = 2;
	localparam int BIA_ST_W = 3;
	typedef logic [7:0] bia_bid_t;
endpackage

// file: pkg/bia_bid_if.sv
// bid bundle between the source logic and the arbiter
`timescale 1ns/1ps
interface bia_bid_if;
	logic [17:0][7:0] bid;
	logic [17:0] live;
	logic [5:0] threshold;
	logic tick;
	logic [7:0] win;
	logic win_valid;
	logic above;
	modport src(output bid, live, threshold, tick, input win, win_valid, above);
	modport arb(input bid, live, threshold, tick, output win, win_valid, above);
endinterface

// file: logic/bia_edge_sync.sv
// two flop synchroniser with edge pulse
`timescale 1ns/1ps
module bia_edge_sync #(
	parameter bit RISE = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic level,
	output logic edge_pulse
);
	logic meta;
	logic last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// start at the pin's idle level so no output or edge follows reset
			meta <= ~RISE;
			level <= ~RISE;
			last <= ~RISE;
		end else begin
			meta <= pin;
			level <= meta;
			last <= level;
		end
	end
	assign edge_pulse = RISE ? (level & ~last) : (~level & last);
endmodule

// file: logic/bia_arbiter.sv
// bid comparison sampled once per crystal tick
`timescale 1ns/1ps
module bia_arbiter (
	input wire logic pclk,
	input wire logic presetn,
	bia_bid_if.arb bus
);
	import bia_pkg::*;
	logic [7:0] best;
	logic found;
	logic over;
	always_comb begin
		best = BIA_NO_BID;
		found = 1'b0;
		over = 1'b0;
		for (int i = 0; i < BIA_NSRC; i++) begin
			if (bus.live[i]) begin
				// numeric max: leading ones and then highest channel win [R14] [R16]
				if (!found || bus.bid[i] > best) begin
					best = bus.bid[i];
				end
				found = 1'b1;
				if (bus.bid[i][7:2] > bus.threshold) begin
					over = 1'b1; // [R04] [R16]
				end
			end
		end
	end
	// sample at crystal rate [R03]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.win <= BIA_NO_BID;
			bus.win_valid <= 1'b0;
			bus.above <= 1'b0;
		end else if (bus.tick) begin
			bus.win <= best;
			bus.win_valid <= found;
			bus.above <= over; // [R18]
		end
	end
endmodule

// file: logic/bia_top.sv
// bidding interrupt arbiter with apb registers and global pointers
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module bia_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crystal_clock_input,
	input wire logic interrupt_ack_strobe_n,
	input wire logic [3:0][3:0] rx_count,
	input wire logic [3:0] rx_error,
	input wire logic [3:0][7:0] rx_data,
	input wire logic [3:0][3:0] tx_space,
	input wire logic [3:0] break_detect,
	input wire logic [3:0] change_of_state_source,
	input wire logic [1:0] timer_expired,
	output logic rx_pop,
	output logic [1:0] rx_pop_ch,
	output logic tx_push,
	output logic [1:0] tx_push_ch,
	output logic [7:0] tx_push_data,
	output logic bid_request,
	output logic [7:0] vector_out,
	output logic vector_oe,
	output logic irq
);
	import bia_pkg::*;

	bia_bid_if bids();

	logic [7:0] interrupt_control_setting;
	logic [7:0] vector_base_value;
	logic [7:0] current_interrupt_capture;
	logic [17:0] source_enable;
	logic [11:0] break_pri;
	logic [11:0] cos_pri;
	logic [3:0] ct_pri;
	logic [BIA_ST_W-1:0] int_status;
	logic [BIA_ST_W-1:0] int_mask;
	logic [BIA_ST_W-1:0] events;
	logic xtal_tick;
	logic ack_level;
	logic ack_fall;
	logic above_last;
	logic rd_err;
	logic [31:0] next_prdata;
	logic next_err;
	logic wr_hit;
	logic rd_hit;
	logic refresh;
	logic [1:0] cap_ch;
	logic cap_is_rx;
	logic cap_is_tx;
	logic [2:0] gcount;
	logic [7:0] next_vector;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	bia_edge_sync #(.RISE(1'b1)) u_xtal (
		.pclk(pclk),
		.presetn(presetn),
		.pin(crystal_clock_input),
		.level(),
		.edge_pulse(xtal_tick)
	);

	bia_edge_sync #(.RISE(1'b0)) u_ack (
		.pclk(pclk),
		.presetn(presetn),
		.pin(interrupt_ack_strobe_n),
		.level(ack_level),
		.edge_pulse(ack_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// bid formation

	assign bids.tick = xtal_tick;
	assign bids.threshold = interrupt_control_setting[7:2]; // [R16]

	for (genvar c = 0; c < BIA_NCH; c++) begin : g_ch
		logic [3:0] rx_m1;
		logic [3:0] tx_m1;
		assign rx_m1 = rx_count[c] - 4'h1;
		assign tx_m1 = tx_space[c] - 4'h1;
		// receiver: count, error, 11, channel [R01] [R02] [R13]
		assign bids.bid[c] = {rx_m1[2:0], rx_error[c], BIA_RX_LOW, 2'(c)};
		assign bids.live[c] = source_enable[c] & (rx_count[c] != 4'h0); // [R15]
		// transmitter: 0, count, 10, channel [R13]
		assign bids.bid[BIA_NCH + c] = {1'b0, tx_m1[2:0], BIA_TX_LOW, 2'(c)};
		assign bids.live[BIA_NCH + c] = source_enable[BIA_NCH + c] & (tx_space[c] != 4'h0); // [R15]
		// break and change of state carry programmed priority [R02] [R14]
		assign bids.bid[2*BIA_NCH + c] = {break_pri[3*c +: 3], BIA_T_BRK, 2'(c)};
		assign bids.live[2*BIA_NCH + c] = source_enable[2*BIA_NCH + c] & break_detect[c];
		assign bids.bid[3*BIA_NCH + c] = {cos_pri[3*c +: 3], BIA_T_COS, 2'(c)};
		assign bids.live[3*BIA_NCH + c] =
			source_enable[3*BIA_NCH + c] & change_of_state_source[c];
	end

	for (genvar t = 0; t < BIA_NCT; t++) begin : g_ct
		// timer: priority, 0, 101, channel of its block [R13] [R14]
		assign bids.bid[4*BIA_NCH + t] = {ct_pri[2*t +: 2], 1'b0, BIA_T_CT, 2'(2*t)};
		assign bids.live[4*BIA_NCH + t] = source_enable[4*BIA_NCH + t] & timer_expired[t]; // [R15]
	end

	bia_arbiter u_arb (
		.pclk(pclk),
		.presetn(presetn),
		.bus(bids)
	);

	assign bid_request = bids.above; // [R04] [R18]

	////////////////////////////////////////////////////////////////////////
	// apb decode

	assign pready = 1'b1;
	assign pslverr = psel & penable & rd_err;
	assign wr_hit = psel & penable & pwrite;
	assign rd_hit = psel & penable & ~pwrite;
	assign refresh = wr_hit & (paddr == BIA_A_CMD) & pwdata[0];

	// captured value fields; no storage of their own [R12]
	assign cap_ch = current_interrupt_capture[1:0];
	assign cap_is_rx = current_interrupt_capture[3:2] == BIA_RX_LOW;
	assign cap_is_tx = current_interrupt_capture[3:2] == BIA_TX_LOW;

	always_comb begin
		gcount = 3'h0;
		if (cap_is_rx) begin
			gcount = current_interrupt_capture[7:5]; // [R11]
		end else if (cap_is_tx) begin
			gcount = current_interrupt_capture[6:4]; // [R11]
		end
	end

	always_comb begin
		next_prdata = 32'h0;
		next_err = 1'b0;
		case (paddr)
			BIA_A_CTRL: next_prdata[7:0] = interrupt_control_setting;
			BIA_A_VBASE: next_prdata[7:0] = vector_base_value;
			BIA_A_CAPT: next_prdata[7:0] = current_interrupt_capture; // [R07]
			BIA_A_CMD: next_prdata = 32'h0;
			BIA_A_GCOUNT: next_prdata[2:0] = gcount; // [R11]
			BIA_A_GCHAN: next_prdata[1:0] = cap_ch; // [R11]
			BIA_A_GRX: next_prdata[7:0] = rx_data[cap_ch]; // [R09] [R08]
			BIA_A_GTX: next_prdata = 32'h0;
			BIA_A_SRCEN: next_prdata[17:0] = source_enable;
			BIA_A_BRKPRI: next_prdata[11:0] = break_pri;
			BIA_A_COSPRI: next_prdata[11:0] = cos_pri;
			BIA_A_CTPRI: next_prdata[3:0] = ct_pri;
			BIA_A_STAT: next_prdata[BIA_ST_W-1:0] = int_status;
			BIA_A_MASK: next_prdata[BIA_ST_W-1:0] = int_mask;
			default: next_err = 1'b1;
		endcase
	end

	// read data and error prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			rd_err <= 1'b0;
		end else if (psel & ~penable) begin
			prdata <= pwrite ? 32'h0 : next_prdata;
			rd_err <= next_err;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_control_setting <= BIA_RST_CTRL;
			vector_base_value <= BIA_RST_VBASE;
			source_enable <= BIA_RST_SRCEN;
			break_pri <= 12'h000;
			cos_pri <= 12'h000;
			ct_pri <= 4'h0;
			int_mask <= '0;
		end else if (wr_hit) begin
			case (paddr)
				BIA_A_CTRL: interrupt_control_setting <= pwdata[7:0];
				BIA_A_VBASE: vector_base_value <= pwdata[7:0];
				BIA_A_SRCEN: source_enable <= pwdata[17:0];
				BIA_A_BRKPRI: break_pri <= pwdata[11:0];
				BIA_A_COSPRI: cos_pri <= pwdata[11:0];
				BIA_A_CTPRI: ct_pri <= pwdata[3:0];
				BIA_A_MASK: int_mask <= pwdata[BIA_ST_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// capture register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_interrupt_capture <= BIA_NO_BID;
		end else if (ack_fall | refresh) begin // [R06]
			current_interrupt_capture <= bids.win_valid ? bids.win : BIA_NO_BID; // [R05]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// global pointer side effects

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_pop <= 1'b0;
			rx_pop_ch <= 2'h0;
			tx_push <= 1'b0;
			tx_push_ch <= 2'h0;
			tx_push_data <= 8'h00;
		end else begin
			rx_pop <= rd_hit & (paddr == BIA_A_GRX) & cap_is_rx; // [R09]
			tx_push <= wr_hit & (paddr == BIA_A_GTX) & cap_is_tx; // [R10]
			if (rd_hit & (paddr == BIA_A_GRX)) begin
				rx_pop_ch <= cap_ch; // [R08]
			end
			if (wr_hit & (paddr == BIA_A_GTX)) begin
				tx_push_ch <= cap_ch; // [R10]
				tx_push_data <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// vector output

	always_comb begin
		case (interrupt_control_setting[1:0]) // [R17] [R08]
			BIA_VF_FULL: next_vector = vector_base_value;
			BIA_VF_CH: next_vector = {vector_base_value[7:2], cap_ch};
			BIA_VF_TYPE: next_vector = {vector_base_value[7:5], current_interrupt_capture[4:0]};
			default: next_vector = BIA_VEC_INHIBIT;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_out <= BIA_VEC_INHIBIT;
			vector_oe <= 1'b0;
		end else begin
			vector_out <= next_vector;
			vector_oe <= ~ack_level;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear, set wins

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			above_last <= 1'b0;
		end else begin
			above_last <= bids.above;
		end
	end

	always_comb begin
		events = '0;
		events[BIA_ST_REQ] = bids.above & ~above_last;
		events[BIA_ST_CAPT] = ack_fall | refresh;
		events[BIA_ST_MISS] = (rd_hit & (paddr == BIA_A_GRX) & ~cap_is_rx)
			| (wr_hit & (paddr == BIA_A_GTX) & ~cap_is_tx);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= '0;
		end else if (wr_hit & (paddr == BIA_A_STAT)) begin
			int_status <= (int_status & ~pwdata[BIA_ST_W-1:0]) | events;
		end else begin
			int_status <= int_status | events;
		end
	end

	assign irq = |(int_status & int_mask);
endmodule

// file: verification/bia_checker_asserts.sv
// concurrent checks on the arbiter's top ports
`timescale 1ns/1ps
module bia_checker
	import bia_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic interrupt_ack_strobe_n,
	input wire logic rx_pop,
	input wire logic tx_push,
	input wire logic [7:0] tx_push_data,
	input wire logic vector_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////
	sequence s_ack_low;
		$fell(interrupt_ack_strobe_n) ##1 !interrupt_ack_strobe_n [*3];
	endsequence
	sequence s_ack_gone;
		$rose(interrupt_ack_strobe_n);
	endsequence
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_access: assert property (pslverr |-> psel && penable && prdata == 32'h0)
		else $error("pslverr outside access");
	a_unmapped_err: assert property (psel && penable && paddr == 8'h3C |-> pslverr)
		else $error("unmapped not refused");
	a_pop_cause: assert property (rx_pop |-> $past(psel && penable && !pwrite && paddr == BIA_A_GRX))
		else $error("pop without global read");
	a_pop_single: assert property (rx_pop |=> !rx_pop)
		else $error("pop too long");
	a_push_cause: assert property (tx_push |-> $past(psel && penable && pwrite && paddr == BIA_A_GTX)
		&& tx_push_data == $past(pwdata[7:0]))
		else $error("push without global write");
	a_push_single: assert property (tx_push |=> !tx_push)
		else $error("push too long");
	a_ack_drives: assert property (s_ack_low |-> ##[0:3] vector_oe)
		else $error("vector not driven");
	a_ack_release: assert property (s_ack_gone |-> ##[1:6] !vector_oe)
		else $error("vector not released");
endmodule

// file: verification/bia_host_model.sv
// host model: pulses the acknowledge pin and takes the vector
`timescale 1ns/1ps
module bia_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [3:0] hold,
	input wire logic [7:0] vector_out,
	input wire logic vector_oe,
	output logic ack_n,
	output logic [7:0] vec_seen,
	output logic done
);
	logic [3:0] cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_n <= 1'b1;
			cnt <= 4'h0;
			vec_seen <= 8'h00;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (go && ack_n) begin
				ack_n <= 1'b0;
				cnt <= hold;
			end else if (!ack_n) begin
				if (cnt != 4'h0) begin
					cnt <= cnt - 4'h1;
				end else begin
					ack_n <= 1'b1;
					done <= 1'b1;
					vec_seen <= vector_oe ? vector_out : 8'h00;
				end
			end
		end
	end
endmodule

// file: verification/testbench.sv
// self-checking bench for the bidding interrupt arbiter
`timescale 1ns/1ps
module testbench;
	import bia_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic xtal = 1'b0;
	logic [3:0][3:0] rx_count = 16'h0;
	logic [3:0] rx_error = 4'h0;
	logic [3:0][7:0] rx_data = 32'h44332211;
	logic [3:0][3:0] tx_space = 16'h0;
	logic [3:0] break_detect = 4'h2;
	logic [3:0] change_of_state_source = 4'h2;
	logic [1:0] timer_expired = 2'h2;
	logic host_go = 1'b0;
	logic [3:0] host_hold = 4'h6;
	logic ack_n, host_done, pready, pslverr, rerr, rx_pop, tx_push, bid_request, vector_oe, irq;
	logic [7:0] vec_seen, vector_out, tx_push_data;
	logic [31:0] prdata, rd;
	logic [1:0] rx_pop_ch, tx_push_ch;
	int err_count = 0;
	int compares = 0;
	int xc = 0;
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		xc <= (xc == 4) ? 0 : xc + 1;
		if (xc == 4) begin
			xtal <= ~xtal;
		end
	end
	bia_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .crystal_clock_input(xtal), .interrupt_ack_strobe_n(ack_n), .rx_count,
		.rx_error, .rx_data, .tx_space, .break_detect, .change_of_state_source, .timer_expired,
		.rx_pop, .rx_pop_ch, .tx_push, .tx_push_ch, .tx_push_data, .bid_request, .vector_out,
		.vector_oe, .irq);
	bia_host_model host (.pclk, .presetn, .go(host_go), .hold(host_hold), .vector_out,
		.vector_oe, .ack_n, .vec_seen, .done(host_done));
	////////////////////////////////
	task automatic report_and_stop;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h", $time, m, got);
			err_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			chk(1'b0, 1'b1, "bus hang");
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e, "read");
	endtask
	task automatic settle;
		repeat (30) @(posedge pclk);
	endtask
	////////////////////////////////
	task automatic t_regs;
		rdc(BIA_A_CTRL, BIA_RST_CTRL);
		rdc(BIA_A_VBASE, BIA_RST_VBASE);
		rdc(BIA_A_SRCEN, BIA_RST_SRCEN);
		wr(BIA_A_GCOUNT, 32'h7);
		rdc(BIA_A_GCOUNT, 32'h0);
		apb(1'b0, 8'h3C, 32'h0);
		chk(rerr, 1'b1, "slverr");
		$display("t_regs done");
	endtask
	task automatic t_rx;
		rx_count[1] <= 4'h3;
		wr(BIA_A_SRCEN, 32'h2);
		settle();
		chk(bid_request, 1'b1, "req");
		wr(BIA_A_CMD, 32'h1);
		rdc(BIA_A_CAPT, 32'h4D);
		rdc(BIA_A_GCOUNT, 32'h2);
		rdc(BIA_A_GCHAN, 32'h1);
		rdc(BIA_A_GRX, 32'h22);
		@(negedge pclk);
		chk({rx_pop, rx_pop_ch}, 3'b101, "pop");
		wr(BIA_A_CTRL, 32'h4C);
		settle();
		chk(bid_request, 1'b0, "req eq");
		wr(BIA_A_CTRL, 32'h48);
		settle();
		chk(bid_request, 1'b1, "req gt");
		$display("t_rx done");
	endtask
	task automatic t_tie;
		rx_count[0] <= 4'h1;
		rx_count[3] <= 4'h1;
		wr(BIA_A_CTRL, 32'h0);
		wr(BIA_A_SRCEN, 32'h9);
		settle();
		wr(BIA_A_CMD, 32'h1);
		rdc(BIA_A_CAPT, 32'h0F);
		rx_error[0] <= 1'b1;
		settle();
		wr(BIA_A_CMD, 32'h1);
		rdc(BIA_A_CAPT, 32'h1C);
		$display("t_tie done");
	endtask
	task automatic t_tx;
		tx_space[2] <= 4'h4;
		wr(BIA_A_SRCEN, 32'h40);
		settle();
		wr(BIA_A_CMD, 32'h1);
		rdc(BIA_A_CAPT, 32'h3A);
		rdc(BIA_A_GCOUNT, 32'h3);
		wr(BIA_A_GTX, 32'hA5);
		@(negedge pclk);
		chk({tx_push, tx_push_ch, tx_push_data}, 11'h6A5, "push");
		@(posedge pclk);
		tx_space[2] <= 4'h0;
		settle();
		wr(BIA_A_CMD, 32'h1);
		rdc(BIA_A_CAPT, 32'h0);
		chk(bid_request, 1'b0, "full tx");
		$display("t_tx done");
	endtask
	task automatic t_src;
		logic [31:0] en [4] = '{32'h200, 32'h2000, 32'h20000, 32'h3FFFF};
		logic [7:0] ex [4] = '{8'hB1, 8'hA5, 8'hD6, 8'hD6};
		wr(BIA_A_BRKPRI, 32'h28);
		wr(BIA_A_COSPRI, 32'h28);
		wr(BIA_A_CTPRI, 32'hC);
		for (int i = 0; i < 4; i++) begin
			wr(BIA_A_SRCEN, en[i]);
			settle();
			wr(BIA_A_CMD, 32'h1);
			rdc(BIA_A_CAPT, ex[i]);
		end
		$display("t_src done");
	endtask
	task automatic t_ack;
		logic [7:0] e [4] = '{8'hA8, 8'hAA, 8'hBA, 8'hFF};
		int n;
		wr(BIA_A_SRCEN, 32'h0);
		settle();
		wr(BIA_A_CMD, 32'h1);
		wr(BIA_A_VBASE, 32'hA8);
		tx_space[2] <= 4'h4;
		wr(BIA_A_SRCEN, 32'h40);
		for (int f = 0; f < 4; f++) begin
			wr(BIA_A_CTRL, f);
			settle();
			host_hold <= f[0] ? 4'hC : 4'h6;
			host_go <= 1'b1;
			@(posedge pclk);
			host_go <= 1'b0;
			n = 0;
			while (host_done !== 1'b1 && n < 40) begin
				@(posedge pclk);
				n++;
			end
			if (n >= 40) begin
				chk(1'b0, 1'b1, "ack hang");
				report_and_stop();
			end
			chk(vec_seen, e[f], "vector");
		end
		rdc(BIA_A_CAPT, 32'h3A);
		$display("t_ack done");
	endtask
	task automatic t_irq;
		wr(BIA_A_STAT, 32'h7);
		wr(BIA_A_MASK, 32'h2);
		@(negedge pclk);
		chk(irq, 1'b0, "irq idle");
		rdc(BIA_A_GRX, 32'h33);
		rdc(BIA_A_STAT, 32'h4);
		wr(BIA_A_CMD, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b1, "irq set");
		wr(BIA_A_STAT, 32'h2);
		@(negedge pclk);
		chk(irq, 1'b0, "irq clear");
		wr(BIA_A_MASK, 32'h0);
		wr(BIA_A_CMD, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b0, "irq masked");
		$display("t_irq done");
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_rx();
		t_tie();
		t_tx();
		t_src();
		t_ack();
		t_irq();
		report_and_stop();
	end
endmodule
bind bia_top bia_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .interrupt_ack_strobe_n, .rx_pop, .tx_push, .tx_push_data,
	.vector_oe);
